//--- src/bpd_pkg.sv
// package for the two-port bidirectional gpio block
// assumes an apb slave with 32-bit data, one register per aligned word
`default_nettype none
package bpd_pkg;
   localparam int unsigned PA_W = 8;
   localparam int unsigned PB_W = 6;
   localparam logic [11:0] OFF_PA_DATA = 12'h000;
   localparam logic [11:0] OFF_PB_DATA = 12'h004;
   localparam logic [11:0] OFF_PA_DIR = 12'h008;
   localparam logic [11:0] OFF_PB_DIR = 12'h00C;
   localparam logic [11:0] OFF_CFG = 12'h010;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
   localparam logic [PA_W-1:0] PA_DIR_RST = 8'h00;
   localparam logic [PB_W-1:0] PB_DIR_RST = 6'h00;
   localparam int unsigned CFG_IRQ_LEVEL_BIT = 0;
   localparam logic IRQ_LEVEL_DEFAULT = 1'b1;
   localparam int unsigned PRE_DIV = 2;

   typedef struct packed {
      logic [PA_W-1:0] pa;
      logic [PB_W-1:0] pb;
   } bpd_lines_s;

   typedef enum logic [0:0] {
      BPD_IRQ_EDGE,
      BPD_IRQ_EDGE_LEVEL
   } bpd_irq_mode_e;
endpackage
`default_nettype wire

//--- src/bpd_sync.sv
// three-flop input sampler; a change counts once stages two and three agree
// assumes asynchronous inputs and a single clock domain
`default_nettype none
module bpd_sync #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] d_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // per bit: glitch of one cycle past stage two is filtered
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               q_r[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
               q_r[i] <= s3_r[i];
            end
         end
      end
   endgenerate

   assign d_out = q_r;
endmodule
`default_nettype wire

//--- src/bpd_port.sv
// two parallel ports, eight and six lines, per-pin direction, apb registers
// assumes pclk is the bus clock; pins are split into in, out and enable
//
// Summary of operation
// - fourteen pins, eight-line and six-line ports, per-pin direction
// - direction bit one drives the output latch, zero makes the pin input
// - reset clears every direction bit, all pins start as inputs
// - reset leaves the output data latches untouched
// - output pin reads back its latched value, not the pin level
// - data write updates all latch bits, input pins included
// - bus clock runs at half the oscillator frequency; here pclk is halved onto the oscillator output pin
// - low reset input forces the defined startup state
// - interrupt input is edge only or edge and level, fixed at build
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`default_nettype none
module bpd_port #(
   parameter bit IRQ_LEVEL_EN = bpd_pkg::IRQ_LEVEL_DEFAULT
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // oscillator
   input wire logic oscillator_input_pin,
   output logic oscillator_output_pin,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // port pins
   input wire logic [bpd_pkg::PA_W-1:0] eight_line_port_pins_in,
   output logic [bpd_pkg::PA_W-1:0] eight_line_port_pins_out,
   output logic [bpd_pkg::PA_W-1:0] eight_line_port_pins_oe,
   input wire logic [bpd_pkg::PB_W-1:0] six_line_port_pins_in,
   output logic [bpd_pkg::PB_W-1:0] six_line_port_pins_out,
   output logic [bpd_pkg::PB_W-1:0] six_line_port_pins_oe,
   // external interrupt
   input wire logic irq_n_pin,
   output logic irq_req
);
   bpd_pkg::bpd_lines_s latch_r;
   bpd_pkg::bpd_lines_s dir_r;
   bpd_pkg::bpd_lines_s pin_sync;
   bpd_pkg::bpd_irq_mode_e irq_mode;
   logic [0:0] irq_sync;
   logic irq_prev_r;
   logic irq_edge_r;
   logic osc_div_r;
   logic setup;
   logic access;
   logic wr_en;
   logic rd_en;
   logic [31:0] rdata_nxt;
   logic err_nxt;

   assign irq_mode = IRQ_LEVEL_EN ? bpd_pkg::BPD_IRQ_EDGE_LEVEL
                                  : bpd_pkg::BPD_IRQ_EDGE;

   // one data + direction latch per pin, both ports
   function automatic logic [7:0] mix(input logic [7:0] lat,
                                      input logic [7:0] dir,
                                      input logic [7:0] pin);
      mix = (lat & dir) | (pin & ~dir);
   endfunction

   bpd_sync #(.W(bpd_pkg::PA_W + bpd_pkg::PB_W)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d_in({eight_line_port_pins_in, six_line_port_pins_in}),
      .d_out(pin_sync)
   );

   // sampled active high: the sampler's reset zero matches an idle pin
   bpd_sync #(.W(1)) u_irq_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d_in(~irq_n_pin),
      .d_out(irq_sync)
   );

   // setup cycle answers with ready held low, access cycle completes
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_en = access && pwrite && pready;
   assign rd_en = setup && !pwrite;

   // pclk halved onto the oscillator output pin; the oscillator input is unused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_div_r <= 1'b0;
      end else begin
         osc_div_r <= ~osc_div_r;
      end
   end

   // data latches carry no reset: contents undefined until written
   always_ff @(posedge pclk) begin
      if (wr_en && paddr == bpd_pkg::OFF_PA_DATA) begin
         latch_r.pa <= pwdata[bpd_pkg::PA_W-1:0];
      end
      if (wr_en && paddr == bpd_pkg::OFF_PB_DATA) begin
         latch_r.pb <= pwdata[bpd_pkg::PB_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r.pa <= bpd_pkg::PA_DIR_RST;
         dir_r.pb <= bpd_pkg::PB_DIR_RST;
      end else begin
         if (wr_en && paddr == bpd_pkg::OFF_PA_DIR) begin
            dir_r.pa <= pwdata[bpd_pkg::PA_W-1:0];
         end
         if (wr_en && paddr == bpd_pkg::OFF_PB_DIR) begin
            dir_r.pb <= pwdata[bpd_pkg::PB_W-1:0];
         end
      end
   end

   // pin drivers registered; latch x before first write is masked only on pins whose direction bit is zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eight_line_port_pins_out <= '0;
         six_line_port_pins_out <= '0;
         eight_line_port_pins_oe <= '0;
         six_line_port_pins_oe <= '0;
      end else begin
         eight_line_port_pins_out <= latch_r.pa & dir_r.pa;
         six_line_port_pins_out <= latch_r.pb & dir_r.pb;
         eight_line_port_pins_oe <= dir_r.pa;
         six_line_port_pins_oe <= dir_r.pb;
      end
   end

   // irq: falling edge sticky until read, or low level when enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_prev_r <= 1'b0;
         irq_edge_r <= 1'b0;
         irq_req <= 1'b0;
      end else begin
         irq_prev_r <= irq_sync[0];
         // set wins over the read-clear
         if (!irq_prev_r && irq_sync[0]) begin
            irq_edge_r <= 1'b1;
         end else if (rd_en && paddr == bpd_pkg::OFF_IRQ_STAT) begin
            irq_edge_r <= 1'b0;
         end
         irq_req <= irq_edge_r || (irq_mode == bpd_pkg::BPD_IRQ_EDGE_LEVEL
                                   && irq_sync[0]);
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      if (paddr == bpd_pkg::OFF_PA_DATA) begin
         rdata_nxt[7:0] = mix(latch_r.pa, dir_r.pa, pin_sync.pa);
      end else if (paddr == bpd_pkg::OFF_PB_DATA) begin
         rdata_nxt[7:0] = mix({2'b00, latch_r.pb}, {2'b00, dir_r.pb},
                              {2'b00, pin_sync.pb});
      end else if (paddr == bpd_pkg::OFF_PA_DIR) begin
         rdata_nxt[7:0] = dir_r.pa;
      end else if (paddr == bpd_pkg::OFF_PB_DIR) begin
         rdata_nxt[5:0] = dir_r.pb;
      end else if (paddr == bpd_pkg::OFF_CFG) begin
         rdata_nxt[bpd_pkg::CFG_IRQ_LEVEL_BIT] = IRQ_LEVEL_EN;
      end else if (paddr == bpd_pkg::OFF_IRQ_STAT) begin
         rdata_nxt[1:0] = {~irq_sync[0], irq_edge_r};
      end else begin
         err_nxt = 1'b1;
      end
   end

   // no wait state: ready and data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && err_nxt;
         if (rd_en) begin
            prdata <= rdata_nxt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oscillator_output_pin <= 1'b0;
      end else begin
         oscillator_output_pin <= osc_div_r;
      end
   end

   dir_reset_a: assert property (@(posedge pclk)
      $rose(presetn) |-> dir_r == '0)
      else $error("direction not cleared by reset");

   sequence dir_write_s;
      wr_en && paddr == bpd_pkg::OFF_PA_DIR;
   endsequence
   oe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      dir_write_s |-> ##2 eight_line_port_pins_oe == $past(pwdata[7:0], 2))
      else $error("output enable not following direction write");
   latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == bpd_pkg::OFF_PB_DATA
      |=> latch_r.pb == $past(pwdata[5:0]))
      else $error("six-line latch not written");
   out_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && paddr == bpd_pkg::OFF_PA_DATA && dir_r.pa == 8'hFF
      |=> prdata[7:0] == $past(latch_r.pa))
      else $error("output pin read not from latch");
   in_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && paddr == bpd_pkg::OFF_PA_DATA && dir_r.pa == 8'h00
      |=> prdata[7:0] == $past(pin_sync.pa))
      else $error("input pin read not from pin");
   bus_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("ready timing wrong");
   // first edge after release still sees the reset value twice
   osc_half_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> osc_div_r != $past(osc_div_r))
      else $error("divider not toggling");
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      IRQ_LEVEL_EN && irq_sync[0] |=> irq_req)
      else $error("level irq missed");
   oe_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      (six_line_port_pins_out & ~six_line_port_pins_oe) == 6'h00)
      else $error("undriven pin shows output data");
endmodule
`default_nettype wire

//--- test/bpd_board.sv
// board-side model of the fourteen port pins
// assumes the port splits each pin into out, in and enable
`default_nettype none
module bpd_board (
   // from the port
   input wire bpd_pkg::bpd_lines_s pin_out,
   input wire bpd_pkg::bpd_lines_s pin_oe,
   // board drivers, released wherever the port drives
   input wire bpd_pkg::bpd_lines_s ext,
   // level seen back at the port
   output var bpd_pkg::bpd_lines_s level
);
   timeunit 1ns;
   timeprecision 1ps;
   // per pin, whoever drives wins; no pin is ever left floating
   assign level = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule
`default_nettype wire

//--- test/bidirectional_port_direction_ctl_tb.sv
// self-checking bench for the two-port gpio block
// assumes the zero-wait-state apb slave and board model beside it
`default_nettype none
module bidirectional_port_direction_ctl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic w;
      logic [11:0] a;
      logic [31:0] d;
      logic e;
   } bpd_row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic irq_n = 1'b1;
   logic osc_in = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, osc_out, irq_req;
   logic [31:0] rd;
   logic er, o;
   bpd_pkg::bpd_lines_s pins_out, pins_oe, pins_lvl;
   bpd_pkg::bpd_lines_s ext = '{pa: 8'h3C, pb: 6'h15};
   int num_errors = 0;
   int num_checks = 0;
   // latches loaded before directions, as software must
   bpd_row_s rows [11] = '{
      '{1, bpd_pkg::OFF_PA_DATA, 32'hA5, 0},
      '{1, bpd_pkg::OFF_PB_DATA, 32'h2A, 0},
      '{0, bpd_pkg::OFF_PA_DIR, 32'h00, 0},
      '{1, bpd_pkg::OFF_PA_DIR, 32'h0F, 0},
      '{1, bpd_pkg::OFF_PB_DIR, 32'h3F, 0},
      '{0, bpd_pkg::OFF_PA_DATA, 32'h35, 0},
      '{0, bpd_pkg::OFF_PB_DATA, 32'h2A, 0},
      '{0, bpd_pkg::OFF_PA_DIR, 32'h0F, 0},
      '{0, bpd_pkg::OFF_CFG, {31'h0, bpd_pkg::IRQ_LEVEL_DEFAULT}, 0},
      '{1, 12'h018, 32'h77, 1},
      '{0, 12'h018, 32'h00, 1}};

   always #12.5 pclk = ~pclk;

   bpd_port dut (.pclk(pclk), .presetn(presetn),
      .oscillator_input_pin(osc_in), .oscillator_output_pin(osc_out),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .eight_line_port_pins_in(pins_lvl.pa),
      .eight_line_port_pins_out(pins_out.pa),
      .eight_line_port_pins_oe(pins_oe.pa),
      .six_line_port_pins_in(pins_lvl.pb),
      .six_line_port_pins_out(pins_out.pb),
      .six_line_port_pins_oe(pins_oe.pb),
      .irq_n_pin(irq_n), .irq_req(irq_req));

   bpd_board board (.pin_out(pins_out), .pin_oe(pins_oe), .ext(ext),
      .level(pins_lvl));

   task automatic conclude();
      if (num_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // answer taken at the rising edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("oe_after_reset", 32'h0, {18'h0, pins_oe});
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
         chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
         if (!rows[i].w) chk("prdata", rows[i].d, rd);
      end
      repeat (3) @(negedge pclk);
      chk("pa_oe", 32'h0F, {24'h0, pins_oe.pa});
      chk("pa_out", 32'h05, {24'h0, pins_out.pa});
      chk("pb_out", 32'h2A, {26'h0, pins_out.pb});
      @(posedge pclk);
      ext.pa <= 8'hC0;
      repeat (8) @(posedge pclk);
      apb(1'b0, bpd_pkg::OFF_PA_DATA, 32'h0, rd, er);
      chk("pa_mixed", 32'hC5, rd);
      @(negedge pclk);
      o = osc_out;
      @(negedge pclk);
      chk("osc_half", {31'h0, ~o}, {31'h0, osc_out});
      // second reset mid-run: directions clear, latches must survive
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      chk("oe_in_reset", 32'h0, {18'h0, pins_oe});
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, bpd_pkg::OFF_PA_DIR, 32'hFF, rd, er);
      apb(1'b0, bpd_pkg::OFF_PA_DATA, 32'h0, rd, er);
      chk("pa_latch_kept", 32'hA5, rd);
      // no false interrupt edge may follow a reset with the pin idle
      @(negedge pclk);
      chk("irq_idle", 32'h0, {31'h0, irq_req});
      @(posedge pclk);
      irq_n <= 1'b0;
      repeat (6) @(posedge pclk);
      irq_n <= 1'b1;
      @(negedge pclk);
      chk("irq_low", 32'h1, {31'h0, irq_req});
      repeat (6) @(negedge pclk);
      chk("irq_held", 32'h1, {31'h0, irq_req});
      apb(1'b0, bpd_pkg::OFF_IRQ_STAT, 32'h0, rd, er);
      chk("irq_stat", 32'h3, rd);
      apb(1'b0, bpd_pkg::OFF_IRQ_STAT, 32'h0, rd, er);
      chk("irq_clear", 32'h2, rd);
      repeat (2) @(negedge pclk);
      chk("irq_done", 32'h0, {31'h0, irq_req});
      conclude();
   end
endmodule
`default_nettype wire
